// >>> core/ccmc_pkg.sv
// package for the cache maintenance control block: addresses, fields, commands, codes
package ccmc_pkg;
	// privileged control register addresses (12-bit)
	localparam logic [11:0] ADDR_M_BEGIN = 12'h07cb;
	localparam logic [11:0] ADDR_M_COMMAND = 12'h07cc;
	localparam logic [11:0] ADDR_M_LOCK_RESULT = 12'h07cd;
	localparam logic [11:0] ADDR_MODE_ENABLE = 12'h07ce;
	localparam logic [11:0] ADDR_S_BEGIN = 12'h05cb;
	localparam logic [11:0] ADDR_S_COMMAND = 12'h05cc;
	localparam logic [11:0] ADDR_S_LOCK_RESULT = 12'h05cd;
	localparam logic [11:0] ADDR_U_BEGIN = 12'h04cb;
	localparam logic [11:0] ADDR_U_COMMAND = 12'h04cc;
	localparam logic [11:0] ADDR_U_LOCK_RESULT = 12'h04cd;
	localparam logic [11:0] ADDR_FLUSH_TRIGGER = 12'h04cf;
	// mode enable register bit positions
	localparam int EN_U_BIT = 0;
	localparam int EN_S_BIT = 1;
	localparam int EN_U_INV_BIT = 8;
	localparam int EN_S_INV_BIT = 9;
	localparam int EN_U_INVALL_BIT = 16;
	localparam int EN_S_INVALL_BIT = 17;
	localparam int EN_U_WBALL_BIT = 24;
	localparam int EN_S_WBALL_BIT = 25;
	localparam logic [31:0] MODE_ENABLE_MASK = 32'h0303_0303;
	localparam logic [31:0] MODE_ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] BEGIN_RESET = 32'h0000_0000;
	localparam logic [2:0] LOCK_RESULT_RESET = 3'h0;
	// cache line size in bytes
	localparam logic [31:0] LINE_BYTES = 32'h0000_0040;
	// privilege levels
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;
	// command codes
	typedef enum logic [4:0] {
		CMD_D_INVAL = 5'b00000,
		CMD_D_WB = 5'b00001,
		CMD_D_WRITEBACK_INVALIDATE_LINE = 5'b00010,
		CMD_D_LOCK = 5'b00011,
		CMD_D_UNLOCK = 5'b00100,
		CMD_D_WRITEBACK_INVALIDATE_LINE_WHOLE = 5'b00110,
		CMD_D_WB_WHOLE = 5'b00111,
		CMD_I_INVAL = 5'b01000,
		CMD_I_LOCK = 5'b01011,
		CMD_I_UNLOCK = 5'b01100,
		CMD_I_INVAL_WHOLE = 5'b01101,
		CMD_C_UNLOCK = 5'b10010,
		CMD_C_LOCK = 5'b10011,
		CMD_D_INVAL_WHOLE = 5'b10111
	} ccmc_cmd_t;
	// target cache of an operation
	typedef enum logic [1:0] {
		TGT_ICACHE = 2'b00,
		TGT_DCACHE = 2'b01,
		TGT_CLUSTER = 2'b10
	} ccmc_tgt_t;
	// lock result codes
	localparam logic [2:0] LOCK_OK = 3'h0;
	localparam logic [2:0] LOCK_WAY_LIMIT = 3'h1;
	localparam logic [2:0] LOCK_PERM_FAIL = 3'h2;
	localparam logic [2:0] LOCK_BUS_ERR = 3'h3;
	// main state machine
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_BUSY = 2'b10
	} ccmc_state_t;
endpackage

// >>> core/ccmc_core.sv
// cache maintenance control: registers, command checks and cache sequencing
// Overview of operation
// - icache lock reports codes 0,1,2,3
// - icache invalidate-whole skips all permission checks
// - dcache by-address ops check R page, W pmp, attrs; icache ops check X
// - dcache lock/unlock check R everywhere, attrs
// - cluster lock/unlock accept X or R pmp
// - lock miss refills; refill bus error fails
// - tag ECC error fails lock, logged per cache
// - dcache lock codes 0..3, 4..7 reserved
// - dcache invalidate-whole writes back protected lines
// - user invalidate-whole upgrades to writeback-invalidate
// - other whole ops run without permission checks
// - writeback bus error reported, whole ops continue
// - lock result field bits 2:0, rest zero
// - lower mode access needs mode enable bit
// - gated commands ignored without per-mode enable
// - enable bits 25/24, 17/16, 9/8, reset zero
// - mode enable register machine mode only
// - flush trigger write flushes, reads zero
// - operation starts next cycle when idle, runs till done; a command written while busy is dropped
// - address advances one line per operation
`timescale 1ns/10ps
module ccmc_core
	import ccmc_pkg::*;
#(
	parameter bit HAS_LOWER_MODES = 1'b1
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// register port from the pipeline
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic [1:0] priv_in,
	output logic [31:0] reg_rdata_out,
	output logic illegal_instr_out,
	output logic flush_pipe_out,
	// permission results for the current address, from translation and protection
	input wire logic page_r_ok_in,
	input wire logic page_x_ok_in,
	input wire logic pmp_r_ok_in,
	input wire logic pmp_w_ok_in,
	input wire logic pmp_x_ok_in,
	input wire logic supervisor_protection_unit_r_ok_in,
	input wire logic supervisor_protection_unit_w_ok_in,
	input wire logic supervisor_protection_unit_x_ok_in,
	input wire logic attr_device_in,
	input wire logic attr_noncache_in,
	// request to caches
	output logic op_valid_out,
	output logic [4:0] op_cmd_out,
	output logic [1:0] op_target_out,
	output logic [31:0] op_addr_out,
	output logic op_check_wr_out,
	// completion from caches
	input wire logic op_done_in,
	input wire logic op_hit_in,
	input wire logic op_way_full_in,
	input wire logic op_refill_err_in,
	input wire logic op_tag_ecc_in,
	input wire logic op_wb_err_in,
	// error reporting
	output logic sram_ecc_log_out,
	output logic cluster_fatal_inc_out,
	output logic wb_bus_err_out
);
	logic [31:0] begin_q [3];
	logic [2:0] result_q [3];
	logic [31:0] mode_en_q;
	ccmc_state_t state_q;
	logic [4:0] cmd_q, eff_cmd;
	logic [1:0] mode_q, mode_idx;
	logic is_cmd_wr, acc_ok, gate_ok, perm_ok, is_whole;
	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	// index of the register bank that an address names, 3 for none
	function automatic logic [1:0] bank_of(input logic [11:0] a);
		if (a == ADDR_M_BEGIN || a == ADDR_M_COMMAND || a == ADDR_M_LOCK_RESULT) begin
			return 2'd2;
		end else if (a == ADDR_S_BEGIN || a == ADDR_S_COMMAND || a == ADDR_S_LOCK_RESULT) begin
			return 2'd1;
		end else if (a == ADDR_U_BEGIN || a == ADDR_U_COMMAND || a == ADDR_U_LOCK_RESULT) begin
			return 2'd0;
		end else begin
			return 2'd3;
		end
	endfunction
	function automatic ccmc_tgt_t target_of(input logic [4:0] c);
		if (c[4:3] == 2'b01) begin
			return TGT_ICACHE;
		end else if (c == CMD_C_LOCK || c == CMD_C_UNLOCK) begin
			return TGT_CLUSTER;
		end else begin
			return TGT_DCACHE;
		end
	endfunction
	function automatic logic whole_of(input logic [4:0] c);
		return c == CMD_I_INVAL_WHOLE || c == CMD_D_INVAL_WHOLE ||
			c == CMD_D_WB_WHOLE || c == CMD_D_WRITEBACK_INVALIDATE_LINE_WHOLE;
	endfunction
	function automatic logic is_lock(input logic [4:0] c);
		return c == CMD_I_LOCK || c == CMD_D_LOCK || c == CMD_C_LOCK;
	endfunction
	// ----------------------------------------
	// access checks
	// ----------------------------------------
	// a lower mode may not touch the machine bank, user mode its own bank only, and only with its enable set
	always_comb begin
		mode_idx = bank_of(reg_addr_in);
		acc_ok = 1'b1;
		if (reg_addr_in == ADDR_MODE_ENABLE) begin
			acc_ok = (priv_in == PRIV_M) && HAS_LOWER_MODES;
		end else if (mode_idx != 2'd3) begin
			if (priv_in != PRIV_M && mode_idx == 2'd2) begin
				acc_ok = 1'b0;
			end else if (priv_in == PRIV_S) begin
				acc_ok = mode_en_q[EN_S_BIT] && mode_idx != 2'd2;
			end else if (priv_in == PRIV_U) begin
				acc_ok = mode_en_q[EN_U_BIT] && mode_idx == 2'd0;
			end
		end
		is_cmd_wr = reg_wr_in && acc_ok && mode_idx != 2'd3 &&
			(reg_addr_in == ADDR_M_COMMAND || reg_addr_in == ADDR_S_COMMAND ||
			reg_addr_in == ADDR_U_COMMAND);
	end
	// per-mode gating and the user invalidate-whole upgrade
	always_comb begin
		logic s;
		logic [4:0] c;
		s = (mode_idx == 2'd1);
		c = reg_wdata_in[4:0];
		eff_cmd = c;
		gate_ok = 1'b1;
		if (mode_idx != 2'd2) begin
			if (c == CMD_D_WB_WHOLE) begin
				gate_ok = s ? mode_en_q[EN_S_WBALL_BIT] : mode_en_q[EN_U_WBALL_BIT];
			end else if (whole_of(c)) begin
				gate_ok = s ? mode_en_q[EN_S_INVALL_BIT] : mode_en_q[EN_U_INVALL_BIT];
			end else if (c == CMD_D_INVAL || c == CMD_D_WRITEBACK_INVALIDATE_LINE || c == CMD_I_INVAL) begin
				gate_ok = s ? mode_en_q[EN_S_INV_BIT] : mode_en_q[EN_U_INV_BIT];
			end
			if (!s && c == CMD_D_INVAL_WHOLE && mode_en_q[EN_U_INVALL_BIT]) begin
				eff_cmd = CMD_D_WRITEBACK_INVALIDATE_LINE_WHOLE;
			end
		end
	end
	// permission result for the latched command
	always_comb begin
		logic attr_ok;
		attr_ok = !attr_device_in && !attr_noncache_in;
		is_whole = whole_of(cmd_q);
		if (is_whole) begin
			perm_ok = 1'b1;
		end else if (target_of(cmd_q) == TGT_ICACHE) begin
			perm_ok = page_x_ok_in && pmp_x_ok_in && supervisor_protection_unit_x_ok_in && attr_ok;
		end else if (cmd_q == CMD_D_LOCK || cmd_q == CMD_D_UNLOCK) begin
			perm_ok = page_r_ok_in && pmp_r_ok_in && supervisor_protection_unit_r_ok_in && attr_ok;
		end else if (target_of(cmd_q) == TGT_CLUSTER) begin
			perm_ok = page_r_ok_in && (pmp_x_ok_in || pmp_r_ok_in) &&
				(supervisor_protection_unit_x_ok_in || supervisor_protection_unit_r_ok_in) && attr_ok;
		end else begin
			perm_ok = page_r_ok_in && pmp_w_ok_in && supervisor_protection_unit_w_ok_in && attr_ok;
		end
	end
	// ----------------------------------------
	// registers
	// ----------------------------------------
	// mode enable register, implemented bits only
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_en_q <= MODE_ENABLE_RESET;
		end else if (reg_wr_in && acc_ok && reg_addr_in == ADDR_MODE_ENABLE) begin
			mode_en_q <= reg_wdata_in & MODE_ENABLE_MASK;
		end
	end
	// begin address registers: software write or line advance
	for (genvar g = 0; g < 3; g++) begin : g_bank
		always_ff @(posedge ref_clk_in or posedge rst_in) begin
			if (rst_in) begin
				begin_q[g] <= BEGIN_RESET;
			end else if (state_q == ST_BUSY && op_done_in && mode_q == 2'(g)) begin
				begin_q[g] <= begin_q[g] + LINE_BYTES;
			end else if (reg_wr_in && acc_ok && mode_idx == 2'(g) && reg_addr_in[3:0] == 4'hb) begin
				begin_q[g] <= reg_wdata_in;
			end
		end
	end
	// lock result per bank, written by a lock outcome
	for (genvar g = 0; g < 3; g++) begin : g_res
		always_ff @(posedge ref_clk_in or posedge rst_in) begin
			if (rst_in) begin
				result_q[g] <= LOCK_RESULT_RESET;
			end else if (state_q == ST_CHECK && !perm_ok && is_lock(cmd_q) && mode_q == 2'(g)) begin
				result_q[g] <= LOCK_PERM_FAIL;
			end else if (state_q == ST_BUSY && op_done_in && is_lock(cmd_q) && mode_q == 2'(g)) begin
				if (op_refill_err_in || op_tag_ecc_in) begin
					result_q[g] <= LOCK_BUS_ERR;
				end else if (op_way_full_in) begin
					result_q[g] <= LOCK_WAY_LIMIT;
				end else begin
					result_q[g] <= LOCK_OK;
				end
			end else if (reg_wr_in && acc_ok && mode_idx == 2'(g) && reg_addr_in[3:0] == 4'hd) begin
				result_q[g] <= reg_wdata_in[2:0];
			end
		end
	end
	// read data, illegal access and flush pulse
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h0000_0000;
			illegal_instr_out <= 1'b0;
			flush_pipe_out <= 1'b0;
		end else begin
			illegal_instr_out <= (reg_wr_in || reg_rd_in) && !acc_ok;
			flush_pipe_out <= reg_wr_in && reg_addr_in == ADDR_FLUSH_TRIGGER;
			reg_rdata_out <= 32'h0000_0000;
			if (reg_rd_in && acc_ok) begin
				if (reg_addr_in == ADDR_MODE_ENABLE) begin
					reg_rdata_out <= mode_en_q;
				end else if (mode_idx != 2'd3 && reg_addr_in[3:0] == 4'hb) begin
					reg_rdata_out <= begin_q[mode_idx];
				end else if (mode_idx != 2'd3 && reg_addr_in[3:0] == 4'hd) begin
					reg_rdata_out <= {29'h0, result_q[mode_idx]};
				end else if (mode_idx != 2'd3 && reg_addr_in[3:0] == 4'hc) begin
					reg_rdata_out <= {27'h0, cmd_q};
				end
			end
		end
	end
	// ----------------------------------------
	// operation sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			cmd_q <= 5'h00;
			mode_q <= 2'd2;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (is_cmd_wr && gate_ok) begin
						cmd_q <= eff_cmd;
						mode_q <= mode_idx;
						state_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					state_q <= perm_ok ? ST_BUSY : ST_IDLE;
				end
				ST_BUSY: begin
					if (op_done_in) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	// cache request; a miss on a non-lock by-address op is dropped by the cache
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			op_valid_out <= 1'b0;
			op_cmd_out <= 5'h00;
			op_target_out <= TGT_DCACHE;
			op_addr_out <= 32'h0000_0000;
			op_check_wr_out <= 1'b0;
		end else begin
			if (state_q == ST_CHECK && perm_ok) begin
				op_valid_out <= 1'b1;
				op_cmd_out <= cmd_q;
				op_target_out <= target_of(cmd_q);
				op_addr_out <= begin_q[mode_q];
				op_check_wr_out <= cmd_q == CMD_D_INVAL_WHOLE;
			end else if (state_q == ST_BUSY && op_done_in) begin
				op_valid_out <= 1'b0;
				op_check_wr_out <= 1'b0;
			end
		end
	end
	// error reporting pulses
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sram_ecc_log_out <= 1'b0;
			cluster_fatal_inc_out <= 1'b0;
			wb_bus_err_out <= 1'b0;
		end else begin
			sram_ecc_log_out <= state_q == ST_BUSY && op_done_in && op_tag_ecc_in &&
				is_lock(cmd_q) && target_of(cmd_q) != TGT_CLUSTER;
			cluster_fatal_inc_out <= state_q == ST_BUSY && op_done_in && op_tag_ecc_in &&
				cmd_q == CMD_C_LOCK;
			wb_bus_err_out <= state_q == ST_BUSY && op_wb_err_in;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	start_next_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		state_q == ST_IDLE && is_cmd_wr && gate_ok |=> state_q == ST_CHECK)
		else $error("command did not start next cycle");
	flush_read_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == ADDR_FLUSH_TRIGGER |=> reg_rdata_out == 32'h0)
		else $error("flush trigger read not zero");
	flush_pulse_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == ADDR_FLUSH_TRIGGER |=> flush_pipe_out)
		else $error("flush write gave no pulse");
	addr_step_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		state_q == ST_BUSY && op_done_in |=>
		begin_q[mode_q] == $past(begin_q[mode_q]) + LINE_BYTES)
		else $error("address did not advance one line");
	lower_access_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_wr_in && priv_in == PRIV_U && !mode_en_q[EN_U_BIT] &&
		reg_addr_in == ADDR_U_COMMAND |=> illegal_instr_out)
		else $error("user access without enable not trapped");
	enable_mask_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(mode_en_q & ~MODE_ENABLE_MASK) == 32'h0)
		else $error("reserved enable bits set");
	perm_drop_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		state_q == ST_CHECK && !perm_ok |=> state_q == ST_IDLE && !op_valid_out)
		else $error("failed check not dropped");
	whole_check_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		state_q == ST_CHECK && whole_of(cmd_q) |=> op_valid_out)
		else $error("whole op blocked by checks");
	user_upgrade_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		state_q == ST_IDLE && is_cmd_wr && mode_idx == 2'd0 &&
		reg_wdata_in[4:0] == CMD_D_INVAL_WHOLE && mode_en_q[EN_U_INVALL_BIT]
		|=> cmd_q == CMD_D_WRITEBACK_INVALIDATE_LINE_WHOLE)
		else $error("user invalidate-whole not upgraded");
	lock_fail_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		state_q == ST_BUSY && op_done_in && op_refill_err_in && is_lock(cmd_q)
		|=> result_q[$past(mode_q)] == LOCK_BUS_ERR)
		else $error("refill error not recorded");
endmodule

// >>> sim/ccmc_cache_model.sv
// behavioural cache side that answers maintenance requests after a set delay
`timescale 1ns/10ps
module ccmc_cache_model (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic op_valid_in,
	input wire logic [3:0] dly_in,
	input wire logic [3:0] fault_in,
	output logic op_done_out,
	output logic op_hit_out,
	output logic op_way_full_out,
	output logic op_refill_err_out,
	output logic op_tag_ecc_out,
	output logic op_wb_err_out
);
	logic [3:0] cnt_q;
	logic act;
	assign act = op_valid_in && !op_done_out;
	// count the service time and give one completion pulse per request
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 4'h0;
			op_done_out <= 1'b0;
			op_wb_err_out <= 1'b0;
		end else begin
			op_done_out <= act && cnt_q == dly_in;
			op_wb_err_out <= act && cnt_q == 4'h0 && fault_in[3];
			cnt_q <= (act && cnt_q != dly_in) ? cnt_q + 4'h1 : 4'h0;
		end
	end
	// status means something only with completion, so show the inverse otherwise
	assign op_hit_out = op_done_out;
	assign op_way_full_out = op_done_out ? fault_in[0] : !fault_in[0];
	assign op_refill_err_out = op_done_out ? fault_in[1] : !fault_in[1];
	assign op_tag_ecc_out = op_done_out ? fault_in[2] : !fault_in[2];
endmodule

// >>> sim/ccmc_core_tb_top.sv
// testbench for the cache maintenance control block
`timescale 1ns/10ps
module ccmc_core_tb_top;
	import ccmc_pkg::*;
	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [1:0] priv = PRIV_M;
	logic [9:0] perm = 10'h3ff;
	logic [3:0] dly = 4'h2;
	logic [3:0] fault = 4'h0;
	logic [2:0] seen = 3'h0;
	logic [31:0] rdata, op_addr, last_addr;
	logic [4:0] op_cmd;
	logic [1:0] op_tgt;
	logic ill, flush, op_valid, chk_wr, last_chk, done, hit, wfull, rferr, tecc, wberr;
	logic ecc_log, fatal_inc, wb_bus, last_ill;
	int failures = 0;
	int compares = 0;
	// clock and sticky capture of the error pulses, cleared by each register write
	always #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) seen <= wr ? 3'h0 : (seen | {wb_bus, fatal_inc, ecc_log});
	ccmc_core dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .priv_in(priv), .reg_rdata_out(rdata),
		.illegal_instr_out(ill), .flush_pipe_out(flush), .page_r_ok_in(perm[0]),
		.page_x_ok_in(perm[1]), .pmp_r_ok_in(perm[2]), .pmp_w_ok_in(perm[3]),
		.pmp_x_ok_in(perm[4]), .supervisor_protection_unit_r_ok_in(perm[5]), .supervisor_protection_unit_w_ok_in(perm[6]),
		.supervisor_protection_unit_x_ok_in(perm[7]), .attr_device_in(!perm[8]), .attr_noncache_in(!perm[9]),
		.op_valid_out(op_valid), .op_cmd_out(op_cmd), .op_target_out(op_tgt),
		.op_addr_out(op_addr), .op_check_wr_out(chk_wr), .op_done_in(done), .op_hit_in(hit),
		.op_way_full_in(wfull), .op_refill_err_in(rferr), .op_tag_ecc_in(tecc),
		.op_wb_err_in(wberr), .sram_ecc_log_out(ecc_log), .cluster_fatal_inc_out(fatal_inc),
		.wb_bus_err_out(wb_bus));
	ccmc_cache_model cache (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .op_valid_in(op_valid),
		.dly_in(dly), .fault_in(fault), .op_done_out(done), .op_hit_out(hit),
		.op_way_full_out(wfull), .op_refill_err_out(rferr), .op_tag_ecc_out(tecc),
		.op_wb_err_out(wberr));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one register access, answer visible on return
	task automatic acc(input logic w, input logic [1:0] p, input logic [11:0] a,
		input logic [31:0] d);
		@(negedge ref_clk_in);
		wr = w;
		rd = !w;
		priv = p;
		addr = a;
		wdata = d;
		@(negedge ref_clk_in);
		wr = 1'b0;
		rd = 1'b0;
	endtask
	task automatic rdchk(input logic [1:0] p, input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, p, a, ZERO);
		chk(rdata, e);
	endtask
	// issue a command and follow the request to the caches until it ends
	task automatic op(input logic [1:0] p, input logic [11:0] a, input ccmc_cmd_t c,
		input logic go, input ccmc_cmd_t ec, input ccmc_tgt_t et);
		int n;
		acc(1'b1, p, a, {27'h000_0000, c});
		last_ill = ill;
		n = 0;
		while (op_valid !== 1'b1 && n < 4) begin
			@(negedge ref_clk_in);
			n++;
		end
		chk({31'h0000_0000, op_valid}, {31'h0000_0000, go});
		if (op_valid === 1'b1) begin
			chk({25'h000_0000, op_cmd, op_tgt}, {25'h000_0000, ec, et});
			last_addr = op_addr;
			last_chk = chk_wr;
			n = 0;
			while (op_valid !== 1'b0 && n < 40) begin
				@(negedge ref_clk_in);
				n++;
			end
			chk({31'h0000_0000, op_valid}, ZERO);
		end
		@(negedge ref_clk_in);
	endtask
	// register reset values, masks and access rights
	task automatic t_regs();
		rdchk(PRIV_M, ADDR_M_LOCK_RESULT, ZERO);
		rdchk(PRIV_M, ADDR_MODE_ENABLE, ZERO);
		rdchk(PRIV_M, ADDR_FLUSH_TRIGGER, ZERO);
		acc(1'b1, PRIV_M, ADDR_MODE_ENABLE, 32'hffff_ffff);
		rdchk(PRIV_M, ADDR_MODE_ENABLE, MODE_ENABLE_MASK);
		acc(1'b1, PRIV_M, ADDR_M_LOCK_RESULT, 32'hffff_ffff);
		rdchk(PRIV_M, ADDR_M_LOCK_RESULT, 32'h0000_0007);
		acc(1'b1, PRIV_U, ADDR_MODE_ENABLE, ZERO);
		chk({31'h0000_0000, ill}, ONE);
		acc(1'b1, PRIV_M, ADDR_MODE_ENABLE, ZERO);
		acc(1'b0, PRIV_S, ADDR_S_LOCK_RESULT, ZERO);
		chk({31'h0000_0000, ill}, ONE);
		acc(1'b1, PRIV_U, ADDR_U_COMMAND, ZERO);
		chk({31'h0000_0000, ill}, ONE);
		acc(1'b1, PRIV_M, ADDR_MODE_ENABLE, 32'h0000_0001);
		acc(1'b0, PRIV_U, ADDR_U_LOCK_RESULT, ZERO);
		chk({31'h0000_0000, ill}, ZERO);
		acc(1'b1, PRIV_U, ADDR_FLUSH_TRIGGER, 32'h1234_5678);
		chk({31'h0000_0000, flush}, ONE);
	endtask
	// lock outcomes, result codes, address advance and error logging
	task automatic t_lock();
		logic [2:0] code [3] = '{LOCK_WAY_LIMIT, LOCK_BUS_ERR, LOCK_BUS_ERR};
		acc(1'b1, PRIV_M, ADDR_M_BEGIN, 32'h0000_1000);
		op(PRIV_M, ADDR_M_COMMAND, CMD_D_LOCK, 1'b1, CMD_D_LOCK, TGT_DCACHE);
		chk(last_addr, 32'h0000_1000);
		rdchk(PRIV_M, ADDR_M_BEGIN, 32'h0000_1000 + LINE_BYTES);
		rdchk(PRIV_M, ADDR_M_LOCK_RESULT, {29'h0000_0000, LOCK_OK});
		for (int i = 0; i < 3; i++) begin
			fault = 4'h1 << i;
			op(PRIV_M, ADDR_M_COMMAND, CMD_D_LOCK, 1'b1, CMD_D_LOCK, TGT_DCACHE);
			rdchk(PRIV_M, ADDR_M_LOCK_RESULT, {29'h0000_0000, code[i]});
			chk({29'h0000_0000, seen}, (i == 2) ? ONE : ZERO);
		end
		op(PRIV_M, ADDR_M_COMMAND, CMD_C_LOCK, 1'b1, CMD_C_LOCK, TGT_CLUSTER);
		chk({29'h0000_0000, seen}, 32'h0000_0002);
		fault = 4'h1;
		op(PRIV_M, ADDR_M_COMMAND, CMD_I_LOCK, 1'b1, CMD_I_LOCK, TGT_ICACHE);
		rdchk(PRIV_M, ADDR_M_LOCK_RESULT, {29'h0000_0000, LOCK_WAY_LIMIT});
		fault = 4'h0;
	endtask
	// permission checks per command kind
	task automatic t_perm();
		perm = 10'h3fb;
		op(PRIV_M, ADDR_M_COMMAND, CMD_D_LOCK, 1'b0, CMD_D_LOCK, TGT_DCACHE);
		rdchk(PRIV_M, ADDR_M_LOCK_RESULT, {29'h0000_0000, LOCK_PERM_FAIL});
		op(PRIV_M, ADDR_M_COMMAND, CMD_C_LOCK, 1'b1, CMD_C_LOCK, TGT_CLUSTER);
		op(PRIV_M, ADDR_M_COMMAND, CMD_D_WB, 1'b1, CMD_D_WB, TGT_DCACHE);
		perm = 10'h3f7;
		op(PRIV_M, ADDR_M_COMMAND, CMD_D_WB, 1'b0, CMD_D_WB, TGT_DCACHE);
		perm = 10'h2ff;
		op(PRIV_M, ADDR_M_COMMAND, CMD_D_INVAL, 1'b0, CMD_D_INVAL, TGT_DCACHE);
		perm = 10'h000;
		op(PRIV_M, ADDR_M_COMMAND, CMD_I_INVAL_WHOLE, 1'b1, CMD_I_INVAL_WHOLE, TGT_ICACHE);
	endtask
	// whole-cache commands, per-mode gating and writeback errors
	task automatic t_whole();
		perm = 10'h3ff;
		op(PRIV_M, ADDR_M_COMMAND, CMD_D_INVAL_WHOLE, 1'b1, CMD_D_INVAL_WHOLE, TGT_DCACHE);
		chk({31'h0000_0000, last_chk}, ONE);
		acc(1'b1, PRIV_M, ADDR_MODE_ENABLE, 32'h0001_0001);
		op(PRIV_U, ADDR_U_COMMAND, CMD_D_INVAL_WHOLE, 1'b1, CMD_D_WRITEBACK_INVALIDATE_LINE_WHOLE, TGT_DCACHE);
		op(PRIV_U, ADDR_U_COMMAND, CMD_D_WB_WHOLE, 1'b0, CMD_D_WB_WHOLE, TGT_DCACHE);
		chk({31'h0000_0000, last_ill}, ZERO);
		op(PRIV_U, ADDR_U_COMMAND, CMD_D_INVAL, 1'b0, CMD_D_INVAL, TGT_DCACHE);
		chk({31'h0000_0000, last_ill}, ZERO);
		acc(1'b1, PRIV_M, ADDR_MODE_ENABLE, 32'h0101_0001);
		perm = 10'h000;
		fault = 4'h8;
		op(PRIV_U, ADDR_U_COMMAND, CMD_D_WB_WHOLE, 1'b1, CMD_D_WB_WHOLE, TGT_DCACHE);
		chk({29'h0000_0000, seen}, 32'h0000_0004);
		fault = 4'h0;
	endtask
	task automatic report_and_stop();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_in = 1'b0;
		t_regs();
		t_lock();
		t_perm();
		t_whole();
		report_and_stop();
	end
	// watchdog against a hang
	initial begin
		#50000;
		failures++;
		report_and_stop();
	end
endmodule
